// ==== core/fcx_ctrl.sv ====
// Local design decisions: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module fcx_ctrl
    import fcx_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire fcx_ahb_req_t ahbReq,
    output var  fcx_ahb_rsp_t ahbRsp,
    input  wire fcx_spi_in_t  spiIn,
    output var  logic         cmdAccept,
    output var  logic         cmdReject,
    output var  logic         xipActive,
    output var  logic         crcBusy
);
    typedef struct packed {
        logic [2:0]     sckS;
        logic [2:0]     csS;
        logic [2:0]     rpS;
        logic [3:0]     io1;
        logic [3:0]     io2;
        logic           boot;
        fcx_phase_t     phase;
        logic [7:0]     shift;
        logic [3:0]     bitCnt;
        logic [4:0]     byteCnt;
        logic [5:0]     clkCnt;
        logic [7:0]     opcode;
        fcx_class_t     cls;
        logic [23:0]    addr;
        logic           crcOk;
        logic [63:0]    crcExp;
        logic [31:0]    crcStart;
        logic [31:0]    crcStop;
        logic [31:0]    crcLeft;
        logic [63:0]    crcVal;
        logic [63:0]    readback;
        logic           busy;
        logic           flagFail;
        logic           unsure;
        logic [7:0]     vcr;
        logic [15:0]    nvcr;
        fcx_dev_state_t devState;
        fcx_width_t     width;
        logic           rstPinEn;
        logic [7:0]     susSector;
        logic           xip;
        logic [7:0]     accCnt;
        logic [7:0]     rejCnt;
        logic           cmdAccept;
        logic           cmdReject;
        logic           busAct;
        logic           busWrite;
        logic [7:0]     busAddr;
        logic           hreadyout;
        logic [31:0]    hrdata;
    } fcx_state_t;

    fcx_state_t s_q;
    fcx_state_t s_d;
    logic       sckRise;
    logic       csFall;
    logic       csRise;
    logic       rpFall;
    logic       addrTake;

    assign sckRise  = s_q.sckS[1] & ~s_q.sckS[2];
    assign csFall   = ~s_q.csS[1] & s_q.csS[2];
    assign csRise   = s_q.csS[1] & ~s_q.csS[2];
    assign rpFall   = ~s_q.rpS[1] & s_q.rpS[2];
    assign addrTake = ahbReq.hsel & ahbReq.htrans[1] & s_q.hreadyout;

    function automatic fcx_class_t classify(input logic [7:0] op);
        case (op)
            OP_READ, OP_FAST: classify = CL_READ;
            OP_RDSR:          classify = CL_STAT;
            OP_PROG:          classify = CL_PROG;
            OP_ERASE:         classify = CL_ERASE;
            OP_WRSR:          classify = CL_NVW;
            OP_WREN:          classify = CL_VW;
            OP_SUSP:          classify = CL_SUSP;
            OP_CRC_ACT:       classify = CL_CRC;
            default:          classify = CL_OTHER;
        endcase
    endfunction

    function automatic logic allowed(input fcx_class_t c, input fcx_dev_state_t st, input logic same);
        case (c)
            CL_READ:  allowed = st != ST_PGMERS;
            CL_STAT:  allowed = 1'b1;
            CL_PROG:  allowed = st == ST_STANDBY || (st == ST_ESUSP && !same);
            CL_ERASE: allowed = st == ST_STANDBY;
            CL_NVW:   allowed = st == ST_STANDBY;
            CL_VW:    allowed = st != ST_PGMERS;
            CL_SUSP:  allowed = st == ST_PGMERS;
            default:  allowed = st == ST_STANDBY;
        endcase
    endfunction

    function automatic logic [63:0] crcStep(input logic [63:0] crc, input logic [7:0] b);
        logic [63:0] c;
        c = crc ^ {56'h0, b};
        for (int i = 0; i < 8; i++)
        begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
        end
        crcStep = c;
    endfunction

    always_comb
    begin
        logic [3:0]  bpc;
        logic [7:0]  nb;
        logic [4:0]  k;
        logic        ok;
        logic        hit;
        logic [63:0] nc;
        bpc = 4'h1;
        nb = '0;
        k = '0;
        ok = 1'b0;
        hit = 1'b0;
        nc = '0;
        s_d = s_q;
        s_d.sckS = {s_q.sckS[1:0], spiIn.sclk};
        s_d.csS = {s_q.csS[1:0], spiIn.csN};
        s_d.rpS = {s_q.rpS[1:0], spiIn.rstPinN};
        s_d.io1 = spiIn.io;
        s_d.io2 = s_q.io1;
        s_d.cmdAccept = 1'b0;
        s_d.cmdReject = 1'b0;
        case (s_q.width)
            W_X2:    begin bpc = 4'h2; nb = {s_q.shift[5:0], s_q.io2[1:0]}; end
            W_X4:    begin bpc = 4'h4; nb = {s_q.shift[3:0], s_q.io2}; end
            default: begin bpc = 4'h1; nb = {s_q.shift[6:0], s_q.io2[0]}; end
        endcase
        if (s_q.boot)
        begin
            s_d.boot = 1'b0;
            s_d.xip = s_q.nvcr[NV_XIP_LSB +: 3] != NV_XIP_OFF;
        end
        if (csFall)
        begin
            s_d.phase = s_q.xip ? PH_ADDR : PH_CMD;
            s_d.opcode = s_q.xip ? OP_FAST : 8'h00;
            s_d.cls = CL_READ;
            s_d.bitCnt = '0;
            s_d.byteCnt = '0;
            s_d.clkCnt = '0;
            s_d.unsure = 1'b0;
        end
        else if (sckRise && !s_q.csS[1] && s_q.phase != PH_IDLE)
        begin
            if (s_q.clkCnt != 6'h3f)
                s_d.clkCnt = s_q.clkCnt + 6'h01;
            if (s_q.phase == PH_DUMMY)
            begin
                // only io0 matters here; io1..io3 are don't care
                if (s_q.xip && s_q.io2[0])
                begin
                    s_d.xip = 1'b0;
                    s_d.vcr[XIP_EN_BIT] = 1'b1;
                end
                else if (!s_q.xip && !s_q.vcr[XIP_EN_BIT] && !s_q.io2[0])
                    s_d.xip = 1'b1;
                s_d.phase = PH_IGN;
            end
            else if (s_q.phase != PH_IGN)
            begin
                s_d.shift = nb;
                s_d.bitCnt = s_q.bitCnt + bpc;
                if (s_q.bitCnt + bpc >= BYTE_BITS)
                begin
                    s_d.bitCnt = '0;
                    k = s_q.byteCnt + 5'h01;
                    if (k != 5'h1f)
                        s_d.byteCnt = k;
                    case (s_q.phase)
                        PH_CMD:
                        begin
                            s_d.opcode = nb;
                            s_d.cls = classify(nb);
                            if (nb == OP_CRC_ACT)
                            begin
                                s_d.phase = PH_CRC;
                                s_d.crcOk = 1'b1;
                            end
                            else if (nb == OP_READ || nb == OP_FAST || nb == OP_PROG || nb == OP_ERASE)
                            begin
                                s_d.phase = PH_ADDR;
                                s_d.byteCnt = '0;
                            end
                            else
                            begin
                                ok = allowed(classify(nb), s_q.devState, 1'b0);
                                s_d.cmdAccept = ok;
                                s_d.cmdReject = !ok;
                                s_d.phase = PH_IGN;
                            end
                        end
                        PH_ADDR:
                        begin
                            s_d.addr = {s_q.addr[15:0], nb};
                            if (k == ADDR_BYTES)
                            begin
                                hit = s_q.devState == ST_ESUSP && s_q.addr[15:8] == s_q.susSector;
                                ok = allowed(s_q.cls, s_q.devState, hit);
                                s_d.unsure = ok && hit && s_q.cls == CL_READ;
                                s_d.cmdAccept = ok;
                                s_d.cmdReject = !ok;
                                s_d.phase = (s_q.opcode == OP_FAST) ? PH_DUMMY : PH_IGN;
                            end
                        end
                        PH_CRC:
                        begin
                            if (k == 5'h02)
                                s_d.crcOk = s_q.crcOk && nb == OP_CRC_SUB;
                            else if (k == 5'h03)
                                s_d.crcOk = s_q.crcOk && nb == OP_CRC_RNG;
                            else if (k >= CRC_EXP_BYTE && k < CRC_START_BYTE)
                                s_d.crcExp = {nb, s_q.crcExp[63:8]};
                            else if (k >= CRC_START_BYTE && k < CRC_STOP_BYTE)
                                s_d.crcStart = {nb, s_q.crcStart[31:8]};
                            else if (k >= CRC_STOP_BYTE && k <= CRC_LAST_BYTE)
                                s_d.crcStop = {nb, s_q.crcStop[31:8]};
                            else
                                s_d.crcOk = 1'b0;
                        end
                        default: s_d.phase = PH_IGN;
                    endcase
                end
            end
        end
        if (csRise)
        begin
            if (s_q.phase == PH_CRC)
            begin
                ok = s_q.crcOk && s_q.byteCnt == CRC_LAST_BYTE && s_q.devState == ST_STANDBY && !s_q.busy;
                s_d.cls = CL_CRC;
                s_d.cmdAccept = ok;
                s_d.cmdReject = !ok;
                if (ok)
                begin
                    s_d.busy = 1'b1;
                    s_d.crcVal = '0;
                    s_d.readback = '0;
                    s_d.crcLeft = s_q.crcStop - s_q.crcStart + 32'h1;
                end
            end
            for (int i = 0; i < 6; i++)
            begin
                if (s_q.xip && s_q.clkCnt == RESYNC_CLKS[i])
                begin
                    s_d.xip = 1'b0;
                    s_d.vcr[XIP_EN_BIT] = 1'b1;
                end
            end
            s_d.phase = PH_IDLE;
        end
        if (rpFall && s_q.rstPinEn && (s_q.width != W_X4 || s_q.csS[1]))
        begin
            s_d.xip = s_q.nvcr[NV_XIP_LSB +: 3] != NV_XIP_OFF;
            s_d.vcr = VCR_RST;
            s_d.readback = '0;
            s_d.phase = PH_IDLE;
        end
        if (s_d.cmdAccept)
            s_d.accCnt = s_q.accCnt + 8'h01;
        if (s_d.cmdReject)
            s_d.rejCnt = s_q.rejCnt + 8'h01;
        if (addrTake)
        begin
            s_d.busAct = 1'b1;
            s_d.busWrite = ahbReq.hwrite;
            s_d.busAddr = ahbReq.haddr[7:0];
            s_d.hreadyout = 1'b0;
        end
        else if (s_q.busAct)
        begin
            s_d.busAct = 1'b0;
            s_d.hreadyout = 1'b1;
            if (s_q.busWrite)
            begin
                case (s_q.busAddr)
                    REG_CTRL:
                    begin
                        s_d.devState = fcx_dev_state_t'(ahbReq.hwdata[1:0]);
                        s_d.width = fcx_width_t'(ahbReq.hwdata[3:2]);
                        s_d.rstPinEn = ahbReq.hwdata[4];
                        s_d.susSector = ahbReq.hwdata[15:8];
                    end
                    REG_VCR:  s_d.vcr = ahbReq.hwdata[7:0] | (s_d.vcr & ~s_q.vcr);
                    REG_NVCR: s_d.nvcr = ahbReq.hwdata[15:0];
                    REG_FLAG:
                        if (ahbReq.hwdata[FLAG_CRC_BIT])
                            s_d.flagFail = 1'b0;
                    REG_CRC_DATA:
                        if (s_q.busy)
                        begin
                            nc = crcStep(s_q.crcVal, ahbReq.hwdata[7:0]);
                            s_d.crcVal = nc;
                            s_d.crcLeft = s_q.crcLeft - 32'h1;
                            if (s_q.crcLeft == 32'h1)
                            begin
                                s_d.busy = 1'b0;
                                s_d.flagFail = nc != s_q.crcExp;
                                if (nc != s_q.crcExp)
                                    s_d.readback = nc;
                            end
                        end
                    default: ;
                endcase
            end
            else
            begin
                case (s_q.busAddr)
                    REG_CTRL:   s_d.hrdata = {16'h0, s_q.susSector, 3'h0, s_q.rstPinEn, s_q.width, s_q.devState};
                    REG_VCR:    s_d.hrdata = {24'h0, s_q.vcr};
                    REG_NVCR:   s_d.hrdata = {16'h0, s_q.nvcr};
                    REG_STATUS: s_d.hrdata = {s_q.rejCnt, s_q.accCnt, s_q.opcode, 4'h0, s_q.unsure,
                                              s_q.flagFail, s_q.busy, s_q.xip};
                    REG_FLAG:   s_d.hrdata = {27'h0, s_q.flagFail, 4'h0};
                    REG_EXP_LO: s_d.hrdata = s_q.crcExp[31:0];
                    REG_EXP_HI: s_d.hrdata = s_q.crcExp[63:32];
                    REG_START:  s_d.hrdata = s_q.crcStart;
                    REG_STOP:   s_d.hrdata = s_q.crcStop;
                    REG_RB_LO:  s_d.hrdata = s_q.readback[31:0];
                    REG_RB_HI:  s_d.hrdata = s_q.readback[63:32];
                    default:    s_d.hrdata = 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0;
            s_q.csS <= 3'h7;
            s_q.rpS <= 3'h7;
            s_q.boot <= 1'b1;
            s_q.vcr <= VCR_RST;
            s_q.nvcr <= NVCR_RST;
            s_q.hreadyout <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    assign ahbRsp = '{hreadyout: s_q.hreadyout, hresp: 1'b0, hrdata: s_q.hrdata};
    assign cmdAccept = s_q.cmdAccept;
    assign cmdReject = s_q.cmdReject;
    assign xipActive = s_q.xip;
    assign crcBusy = s_q.busy;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence busTaken;
        addrTake;
    endsequence
    sequence busWaitOne;
        !s_q.hreadyout ##1 s_q.hreadyout;
    endsequence

    a_bus_wait_state: assert property (busTaken |=> busWaitOne)
        else $error("bus answer not after exactly one wait state");
    a_crc_start_cs: assert property ($rose(s_q.busy) |-> $past(csRise) && s_q.readback == 64'h0)
        else $error("crc started without select deassertion or readback not cleared");
    a_busy_only_stat: assert property (s_q.cmdAccept && $past(s_q.devState) == ST_PGMERS
                                       |-> s_q.cls == CL_STAT || s_q.cls == CL_SUSP)
        else $error("command accepted while program or erase runs");
    a_nv_standby: assert property (s_q.cmdAccept && s_q.cls == CL_NVW |-> $past(s_q.devState) == ST_STANDBY)
        else $error("nonvolatile write accepted outside standby");
    a_vol_not_busy: assert property (s_q.cmdAccept && s_q.cls == CL_VW |-> $past(s_q.devState) != ST_PGMERS)
        else $error("volatile write accepted during program or erase");
    a_susp_in_busy: assert property (s_q.cmdAccept && s_q.cls == CL_SUSP |-> $past(s_q.devState) == ST_PGMERS)
        else $error("suspend accepted outside program or erase");
    a_ssusp_block: assert property (s_q.cmdAccept && $past(s_q.devState) == ST_SSUSP
                                    |-> s_q.cls != CL_PROG && s_q.cls != CL_ERASE)
        else $error("program or erase accepted in short suspend");
    a_esusp_sector: assert property (s_q.cmdAccept && s_q.cls == CL_PROG && $past(s_q.devState) == ST_ESUSP
                                     |-> s_q.addr[23:16] != $past(s_q.susSector))
        else $error("program accepted to suspended sector");
    a_xip_exit_bit: assert property ($fell(s_q.xip) |-> s_q.vcr[XIP_EN_BIT])
        else $error("xip left without restoring enable bit");
    a_one_verdict: assert property (!(s_q.cmdAccept && s_q.cmdReject))
        else $error("accept and reject in the same cycle");
endmodule
`default_nettype wire

// ==== common/fcx_pkg.sv ====
package fcx_pkg;
    localparam logic [7:0] OP_CRC_ACT = 8'h9b;
    localparam logic [7:0] OP_CRC_SUB = 8'h27;
    localparam logic [7:0] OP_CRC_RNG = 8'hfe;
    localparam logic [7:0] OP_READ    = 8'h03;
    localparam logic [7:0] OP_FAST    = 8'h0b;
    localparam logic [7:0] OP_RDSR    = 8'h05;
    localparam logic [7:0] OP_PROG    = 8'h02;
    localparam logic [7:0] OP_ERASE   = 8'hd8;
    localparam logic [7:0] OP_WRSR    = 8'h01;
    localparam logic [7:0] OP_WREN    = 8'h06;
    localparam logic [7:0] OP_SUSP    = 8'h75;
    localparam logic [63:0] CRC_POLY_REFL = 64'hc96c5795d7870f42;
    localparam logic [4:0] CRC_LAST_BYTE  = 5'h13;
    localparam logic [4:0] CRC_START_BYTE = 5'h0c;
    localparam logic [4:0] CRC_STOP_BYTE  = 5'h10;
    localparam logic [4:0] CRC_EXP_BYTE   = 5'h04;
    localparam logic [4:0] ADDR_BYTES     = 5'h03;
    localparam logic [3:0] BYTE_BITS      = 4'h8;
    localparam logic [5:0] RESYNC_CLKS [6] = '{6'h07, 6'h09, 6'h0d, 6'h11, 6'h19, 6'h21};
    localparam int          XIP_EN_BIT    = 3;
    localparam int          NV_XIP_LSB    = 9;
    localparam logic [2:0]  NV_XIP_OFF    = 3'h7;
    localparam int          FLAG_CRC_BIT  = 4;
    localparam logic [7:0]  VCR_RST       = 8'hff;
    localparam logic [15:0] NVCR_RST      = 16'hffff;
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_VCR       = 8'h04;
    localparam logic [7:0]  REG_NVCR      = 8'h08;
    localparam logic [7:0]  REG_STATUS    = 8'h0c;
    localparam logic [7:0]  REG_FLAG      = 8'h10;
    localparam logic [7:0]  REG_EXP_LO    = 8'h14;
    localparam logic [7:0]  REG_EXP_HI    = 8'h18;
    localparam logic [7:0]  REG_START     = 8'h1c;
    localparam logic [7:0]  REG_STOP      = 8'h20;
    localparam logic [7:0]  REG_RB_LO     = 8'h24;
    localparam logic [7:0]  REG_RB_HI     = 8'h28;
    localparam logic [7:0]  REG_CRC_DATA  = 8'h2c;

    typedef enum logic [1:0] {ST_STANDBY = 2'b00, ST_PGMERS = 2'b01, ST_SSUSP = 2'b10,
                              ST_ESUSP = 2'b11} fcx_dev_state_t;
    typedef enum logic [1:0] {W_X1 = 2'b00, W_X2 = 2'b01, W_X4 = 2'b10, W_RSV = 2'b11} fcx_width_t;
    typedef enum logic [2:0] {PH_IDLE = 3'b000, PH_CMD = 3'b001, PH_ADDR = 3'b010, PH_DUMMY = 3'b011,
                              PH_CRC = 3'b100, PH_IGN = 3'b101} fcx_phase_t;
    typedef enum logic [3:0] {CL_READ = 4'b0000, CL_STAT = 4'b0001, CL_PROG = 4'b0010, CL_ERASE = 4'b0011,
                              CL_NVW = 4'b0100, CL_VW = 4'b0101, CL_SUSP = 4'b0110, CL_CRC = 4'b0111,
                              CL_OTHER = 4'b1000} fcx_class_t;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
    } fcx_ahb_req_t;

    typedef struct packed {
        logic        hreadyout;
        logic        hresp;
        logic [31:0] hrdata;
    } fcx_ahb_rsp_t;

    typedef struct packed {
        logic       sclk;
        logic       csN;
        logic [3:0] io;
        logic       rstPinN;
    } fcx_spi_in_t;
endpackage

// ==== tb/fcx_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module fcx_host
(
    output var logic       sclk,
    output var logic       csN,
    output var logic [3:0] io
);
    initial
    begin
        sclk = 1'b0;
        csN  = 1'b1;
        io   = 4'h0;
    end
    // bits msb first on io0, clock idles low outside frames
    task automatic bits(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
        begin
            io[0] = v[i];
            #62.5 sclk = 1'b1;
            #62.5 sclk = 1'b0;
        end
    endtask
    // nibbles msb first on io3..io0 for quad frames
    task automatic quad(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
        begin
            io = v[4*i +: 4];
            #62.5 sclk = 1'b1;
            #62.5 sclk = 1'b0;
        end
    endtask
    task automatic sel();
        #2 csN = 1'b0;
        #100;
    endtask
    // select rise confirms a crc frame; released lines show the inverse
    task automatic desel();
        #100 csN = 1'b1;
        io = ~io;
        #300;
    endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb
    import fcx_pkg::*;
;
    logic         clk, rst, rstPinN, sclk, csN, acc, rej, xip, busy;
    logic [3:0]   io;
    fcx_ahb_req_t req;
    fcx_ahb_rsp_t rsp;
    fcx_spi_in_t  spi;
    int           n_fail, checks, nA, nR, a0, r0, cyc;
    logic [31:0]  q;
    logic [63:0]  c;
    assign spi = '{sclk: sclk, csN: csN, io: io, rstPinN: rstPinN};
    fcx_ctrl u_dut (.clk(clk), .rst(rst), .ahbReq(req), .ahbRsp(rsp), .spiIn(spi),
        .cmdAccept(acc), .cmdReject(rej), .xipActive(xip), .crcBusy(busy));
    fcx_host u_host (.sclk(sclk), .csN(csN), .io(io));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (acc === 1'b1) nA++;
        if (rej === 1'b1) nR++;
        cyc++;
        if (cyc == 80000)
        begin
            n_fail++;
            close_out();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rdy();
        logic r;
        r = 1'b0;
        while (r !== 1'b1)
        begin
            @(negedge clk);
            r = rsp.hreadyout;
            q = rsp.hrdata;
            @(posedge clk);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{hsel: 1'b1, haddr: {24'h0, a}, htrans: 2'b10, hwrite: w, hsize: 3'h2, hwdata: 32'h0};
        rdy();
        req.htrans <= 2'b00;
        req.hwdata <= d;
        rdy();
        req.hsel <= 1'b0;
    endtask
    task automatic verdict(input logic ok);
        repeat (12) @(posedge clk);
        chk(32'(nA - a0), 32'(ok));
        chk(32'(nR - r0), 32'(!ok));
    endtask
    task automatic cmd(input logic [7:0] op, input logic [23:0] ad, input logic adr, input logic ok);
        a0 = nA;
        r0 = nR;
        u_host.sel();
        u_host.bits({24'h0, op}, 8);
        if (adr) u_host.bits({8'h0, ad}, 24);
        u_host.desel();
        verdict(ok);
    endtask
    task automatic le(input logic [31:0] v, input int n);
        for (int i = 0; i < n; i++) u_host.bits({24'h0, v[8*i+:8]}, 8);
    endtask
    task automatic resetVals();
        ahb(0, REG_VCR, 0);
        chk(q, 32'h000000ff);
        ahb(0, REG_NVCR, 0);
        chk(q, 32'h0000ffff);
        ahb(0, 8'h30, 0);
        chk(q, 32'h0);
        chk(32'({rsp.hresp, xip}), 32'h0);
    endtask
    task automatic stateTable();
        logic [7:0] ops [7] = '{OP_READ, OP_RDSR, OP_PROG, OP_ERASE, OP_WRSR, OP_WREN, OP_SUSP};
        logic [6:0] ok [4] = '{7'b1111110, 7'b0100001, 7'b1100010, 7'b1110010};
        for (int s = 0; s < 4; s++)
        begin
            ahb(1, REG_CTRL, {16'h0055, 6'h0, 2'(s)});
            for (int i = 0; i < 7; i++)
                cmd(ops[i], 24'h010000, i inside {0, 2, 3}, ok[s][6-i]);
        end
        cmd(OP_PROG, 24'h550000, 1, 0);
        cmd(OP_READ, 24'h550000, 1, 1);
        ahb(0, REG_STATUS, 0);
        chk(32'(q[3]), 1);
        ahb(1, REG_CTRL, 0);
    endtask
    task automatic crcRun(input logic [63:0] e, input int n);
        a0 = nA;
        r0 = nR;
        u_host.sel();
        u_host.bits({8'h0, OP_CRC_ACT, OP_CRC_SUB, OP_CRC_RNG}, 24);
        le(e[31:0], 4);
        le(e[63:32], 4);
        le(32'h00000100, 4);
        le(32'h00000101, n);
        u_host.desel();
        verdict(n == 4);
        chk(32'(busy), 32'(n == 4));
    endtask
    task automatic crcChecks();
        c = 64'h0;
        for (int i = 0; i < 16; i++) c = (c[0] ^ 16'h3ca5 >> i & 1) ? (c >> 1) ^ CRC_POLY_REFL : c >> 1;
        for (int p = 0; p < 2; p++)
        begin
            crcRun(c ^ 64'(p == 0), 4);
            ahb(1, REG_CRC_DATA, 32'ha5);
            ahb(1, REG_CRC_DATA, 32'h3c);
            chk(32'(busy), 0);
            ahb(0, REG_FLAG, 0);
            chk(32'(q[FLAG_CRC_BIT]), 32'(p == 0));
            ahb(0, REG_RB_LO, 0);
            chk(q, p == 0 ? c[31:0] : 32'h0);
            ahb(0, REG_RB_HI, 0);
            chk(q, p == 0 ? c[63:32] : 32'h0);
        end
        crcRun(c, 3);
    endtask
    task automatic xipFrame(input logic [7:0] dm, input logic ok, input logic x, input logic q4);
        a0 = nA;
        r0 = nR;
        u_host.sel();
        if (q4)
            u_host.quad({24'h000200, dm}, 8);
        else
            u_host.bits({24'h000200, dm}, 32);
        u_host.desel();
        verdict(ok);
        chk(32'(xip), 32'(x));
    endtask
    task automatic xipEnter();
        ahb(1, REG_VCR, 32'hf7);
        u_host.sel();
        u_host.bits({24'h0, OP_FAST}, 8);
        u_host.bits(32'h000100, 24);
        u_host.bits(32'h0, 8);
        u_host.desel();
        repeat (12) @(posedge clk);
        chk(32'(xip), 1);
    endtask
    task automatic xipChecks();
        xipEnter();
        xipFrame(8'h00, 1, 1, 0);
        xipFrame(8'h80, 1, 0, 0);
        ahb(0, REG_VCR, 0);
        chk(q, 32'hff);
        xipEnter();
        ahb(1, REG_CTRL, 32'h08);
        xipFrame(8'he0, 1, 1, 1);
        xipFrame(8'h10, 1, 0, 1);
        ahb(1, REG_CTRL, 0);
        xipEnter();
        ahb(1, REG_CTRL, 1);
        u_host.sel();
        u_host.bits(32'h1fff, 13);
        u_host.desel();
        repeat (12) @(posedge clk);
        chk(32'(xip), 0);
        ahb(0, REG_CTRL, 0);
        chk(32'(q[1:0]), 1);
        ahb(1, REG_CTRL, 0);
    endtask
    task automatic pinPulse(input logic [31:0] nv, input logic x, input logic [31:0] ctl, input logic hold);
        ahb(1, REG_CTRL, ctl);
        ahb(1, REG_NVCR, nv);
        if (hold)
        begin
            u_host.sel();
            @(posedge clk);
        end
        rstPinN <= 1'b0;
        repeat (5) @(posedge clk);
        rstPinN <= 1'b1;
        repeat (8) @(posedge clk);
        chk(32'(xip), 32'(x));
        if (hold)
            u_host.desel();
    endtask
    task automatic close_out();
        if (n_fail == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        rst = 1'b1;
        rstPinN = 1'b1;
        req = '0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        resetVals();
        stateTable();
        crcChecks();
        xipChecks();
        pinPulse(32'hf1ff, 1, 32'h10, 0);
        pinPulse(32'hffff, 1, 32'h18, 1);
        pinPulse(32'hffff, 0, 32'h10, 0);
        close_out();
    end
endmodule
`default_nettype wire
